// File: src/bdc_top.v
// Purpose : Bridge diagnostic / sense amplifier configuration and static gate
//           current selection registers, with overcurrent filtering.
// Assumes : Register accesses come from the serial interface core on mclk.
// Notes   : Accesses this block does not own are answered with hit low.
//
// Overview of operation
// - Amplifier two level bit: 0 low-side, 1 high-side, resets to 1.
// - Amplifier one level bit: 0 low-side, 1 high-side, resets to 1.
// - Bits 13:12 pick the amplifier two overcurrent filter time 6/10/50/100 us, reset 6 us.
// - Bits 11:10 pick the amplifier one overcurrent filter time with the same codes, reset 6 us.
// - Bit 9 switches amplifier two off and bit 8 amplifier one, both enabled after reset.
// - Bit n-1 turns on the off-state pull-down of half-bridge n.
// - All pull-downs are off after reset.
// - The static current selection register is reached only while the bank selector is 0.
// - Bit 15 of that register picks setting 2 for half-bridge 8 when 1, else setting 1.
// - Bits 14 to 10 pick the setting for half-bridges 7 to 3 the same way.
// - All per-bridge selection bits reset to setting 1.
// - The static current selection register resets to 0x0044.
// - Bits 9 and 8 pick the setting for half-bridges 2 and 1.
// - Bits 7:4 hold static level two and bits 3:0 level one, each resetting to 0100.
// - With the bank selector at 1 the same offset belongs to another register, so decode uses the bank.
`include "bdc_map.vh"
module bdc_top (
	input  wire                   mclk,                       // Core clock, 20 MHz
	input  wire                   rst_n,                      // Async reset, active low
	input  wire [`BDC_ADDR_W-1:0] reg_addr,                   // Register offset
	input  wire                   reg_bank,                   // Register bank selector
	input  wire                   reg_wr,                     // Write strobe, one cycle
	input  wire                   reg_rd,                     // Read strobe, one cycle
	input  wire [`BDC_DATA_W-1:0] reg_wdata,                  // Write data
	output reg  [`BDC_DATA_W-1:0] reg_rdata_ff,               // Read data
	output reg                    reg_ack_ff,                 // Access answered, one cycle
	output reg                    reg_hit_ff,                 // Access owned by this block
	input  wire                   oc1_raw,                    // Amplifier one comparator pin
	input  wire                   oc2_raw,                    // Amplifier two comparator pin
	output wire                   oc1_flag_ff,                // Filtered overcurrent one
	output wire                   oc2_flag_ff,                // Filtered overcurrent two
	output wire                   amp1_level_select,          // 1 high-side, 0 low-side
	output wire                   amp2_level_select,          // 1 high-side, 0 low-side
	output wire [1:0]             overcurrent1_filter_time,   // Filter code, amplifier one
	output wire [1:0]             overcurrent2_filter_time,   // Filter code, amplifier two
	output wire                   amp1_disable,               // Amplifier one off
	output wire                   amp2_disable,               // Amplifier two off
	output wire [7:0]             bridge_offstate_pulldown,   // Pull-down per half-bridge
	output wire [7:0]             bridge_static_current_choice, // 1 setting 2, per half-bridge
	output wire [3:0]             static_current_level_one,   // Static level one code
	output wire [3:0]             static_current_level_two    // Static level two code
);

	// ****************************************************************
	// Address decode
	// ****************************************************************
	wire                   sel_diag;
	wire                   sel_static;
	wire                   wr_diag;
	wire                   wr_static;
	wire [`BDC_DATA_W-1:0] diag_sense_q;
	wire [`BDC_DATA_W-1:0] static_sel_q;

	assign sel_diag   = (reg_addr == `BDC_OFS_DIAG_SENSE);
	assign sel_static = (reg_addr == `BDC_OFS_STATIC_SEL) &&
	                    (reg_bank == `BDC_BANK_STATIC_SEL);
	assign wr_diag    = reg_wr & sel_diag;
	assign wr_static  = reg_wr & sel_static;

	// ****************************************************************
	// Registers
	// ****************************************************************
	bdc_cfg_reg #(
		.WIDTH   (`BDC_DATA_W),
		.RST_VAL (`BDC_RST_DIAG_SENSE)
	) u_diag_sense (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.wr_en    (wr_diag),
		.wr_data  (reg_wdata),
		.value_ff (diag_sense_q)
	);

	bdc_cfg_reg #(
		.WIDTH   (`BDC_DATA_W),
		.RST_VAL (`BDC_RST_STATIC_SEL)
	) u_static_sel (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.wr_en    (wr_static),
		.wr_data  (reg_wdata),
		.value_ff (static_sel_q)
	);

	// ****************************************************************
	// Field outputs
	// ****************************************************************
	assign amp2_level_select        = diag_sense_q[`BDC_F_AMP2_LVL];
	assign amp1_level_select        = diag_sense_q[`BDC_F_AMP1_LVL];
	assign overcurrent2_filter_time = diag_sense_q[`BDC_F_OC2_FILT_HI:`BDC_F_OC2_FILT_LO];
	assign overcurrent1_filter_time = diag_sense_q[`BDC_F_OC1_FILT_HI:`BDC_F_OC1_FILT_LO];
	assign amp2_disable             = diag_sense_q[`BDC_F_AMP2_DIS];
	assign amp1_disable             = diag_sense_q[`BDC_F_AMP1_DIS];
	assign bridge_offstate_pulldown = diag_sense_q[`BDC_F_PULLDOWN_HI:`BDC_F_PULLDOWN_LO];
	// Index n-1 serves half-bridge n
	assign bridge_static_current_choice =
	       static_sel_q[`BDC_F_CHOICE_HI:`BDC_F_CHOICE_LO];
	assign static_current_level_two = static_sel_q[`BDC_F_LEVEL2_HI:`BDC_F_LEVEL2_LO];
	assign static_current_level_one = static_sel_q[`BDC_F_LEVEL1_HI:`BDC_F_LEVEL1_LO];

	// ****************************************************************
	// Register answer
	// ****************************************************************
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_ff <= {`BDC_DATA_W{1'b0}};
			reg_ack_ff   <= 1'b0;
			reg_hit_ff   <= 1'b0;
		end else begin
			reg_ack_ff <= reg_wr | reg_rd;
			reg_hit_ff <= (reg_wr | reg_rd) & (sel_diag | sel_static);
			if (reg_rd) begin
				if (sel_diag) begin
					reg_rdata_ff <= diag_sense_q;
				end else if (sel_static) begin
					reg_rdata_ff <= static_sel_q;
				end else begin
					reg_rdata_ff <= {`BDC_DATA_W{1'b0}};
				end
			end
		end
	end

	// ****************************************************************
	// Overcurrent pins: synchronise, then filter per amplifier
	// ****************************************************************
	wire [1:0] oc_raw;
	wire [1:0] oc_flag;
	wire [1:0] amp_dis;
	wire [3:0] filt_code;
	reg  [1:0] oc_meta_ff;
	reg  [1:0] oc_sync_ff;

	assign oc_raw    = {oc2_raw, oc1_raw};
	assign amp_dis   = {amp2_disable, amp1_disable};
	assign filt_code = {overcurrent2_filter_time, overcurrent1_filter_time};

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			oc_meta_ff <= 2'h0;
			oc_sync_ff <= 2'h0;
		end else begin
			oc_meta_ff <= oc_raw;
			oc_sync_ff <= oc_meta_ff;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_amp
			bdc_oc_filter u_filt (
				.mclk       (mclk),
				.rst_n      (rst_n),
				.oc_sync    (oc_sync_ff[gi]),
				.amp_dis    (amp_dis[gi]),
				.filt_sel   (filt_code[2*gi+1:2*gi]),
				.oc_flag_ff (oc_flag[gi])
			);
		end
	endgenerate

	assign oc1_flag_ff = oc_flag[0];
	assign oc2_flag_ff = oc_flag[1];

endmodule // bdc_top

// File: inc/bdc_map.vh
// Purpose : Offsets, field positions, reset values and timing counts of the
//           bridge diagnostic and current configuration block.
// Assumes : 20 MHz core clock, 5-bit register offsets, one register bank bit.
// Notes   : Definitions only.
`ifndef BDC_MAP_VH
`define BDC_MAP_VH

// ****************************************************************
// Register map
// ****************************************************************
`define BDC_ADDR_W           5
`define BDC_DATA_W           16
`define BDC_OFS_DIAG_SENSE   5'h09
`define BDC_OFS_STATIC_SEL   5'h0A
`define BDC_BANK_STATIC_SEL  1'b0
`define BDC_RST_DIAG_SENSE   16'hC000
`define BDC_RST_STATIC_SEL   16'h0044

// ****************************************************************
// Fields of bridge_diag_and_sense_config
// ****************************************************************
`define BDC_F_AMP2_LVL       15
`define BDC_F_AMP1_LVL       14
`define BDC_F_OC2_FILT_HI    13
`define BDC_F_OC2_FILT_LO    12
`define BDC_F_OC1_FILT_HI    11
`define BDC_F_OC1_FILT_LO    10
`define BDC_F_AMP2_DIS       9
`define BDC_F_AMP1_DIS       8
`define BDC_F_PULLDOWN_HI    7
`define BDC_F_PULLDOWN_LO    0

// ****************************************************************
// Fields of static_gate_current_select
// ****************************************************************
`define BDC_F_CHOICE_HI      15
`define BDC_F_CHOICE_LO      8
`define BDC_F_LEVEL2_HI      7
`define BDC_F_LEVEL2_LO      4
`define BDC_F_LEVEL1_HI      3
`define BDC_F_LEVEL1_LO      0

// ****************************************************************
// Overcurrent filter times
// ****************************************************************
`define BDC_CLK_MHZ          20
`define BDC_OCF_T0_US        6
`define BDC_OCF_T1_US        10
`define BDC_OCF_T2_US        50
`define BDC_OCF_T3_US        100
`define BDC_OCF_T0_CYC       (`BDC_OCF_T0_US * `BDC_CLK_MHZ)
`define BDC_OCF_T1_CYC       (`BDC_OCF_T1_US * `BDC_CLK_MHZ)
`define BDC_OCF_T2_CYC       (`BDC_OCF_T2_US * `BDC_CLK_MHZ)
`define BDC_OCF_T3_CYC       (`BDC_OCF_T3_US * `BDC_CLK_MHZ)
`define BDC_OCF_CNT_W        11

`endif

// File: src/bdc_cfg_reg.v
// Purpose : One read-write configuration register with a reset pattern.
// Assumes : Write strobe and data come from logic on the same clock.
// Notes   : Value holds until the next write or reset.
module bdc_cfg_reg #(
	parameter           WIDTH    = 16,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	input  wire             mclk,     // Core clock
	input  wire             rst_n,    // Async reset, active low
	input  wire             wr_en,    // Write this register
	input  wire [WIDTH-1:0] wr_data,  // Data to store
	output reg  [WIDTH-1:0] value_ff  // Stored value
);

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			value_ff <= RST_VAL;
		end else if (wr_en) begin
			value_ff <= wr_data;
		end
	end

endmodule // bdc_cfg_reg

// File: src/bdc_oc_filter.v
// Purpose : Overcurrent filter: flags an overcurrent held for the chosen time.
// Assumes : oc_sync is already synchronised to mclk.
// Notes   : A drop of the input or a disabled amplifier restarts the filter.
`include "bdc_map.vh"
module bdc_oc_filter #(
	parameter [`BDC_OCF_CNT_W-1:0] T0_CYC = `BDC_OCF_T0_CYC,
	parameter [`BDC_OCF_CNT_W-1:0] T1_CYC = `BDC_OCF_T1_CYC,
	parameter [`BDC_OCF_CNT_W-1:0] T2_CYC = `BDC_OCF_T2_CYC,
	parameter [`BDC_OCF_CNT_W-1:0] T3_CYC = `BDC_OCF_T3_CYC
) (
	input  wire       mclk,      // Core clock
	input  wire       rst_n,     // Async reset, active low
	input  wire       oc_sync,   // Synchronised raw overcurrent
	input  wire       amp_dis,   // Amplifier switched off
	input  wire [1:0] filt_sel,  // Filter time code
	output reg        oc_flag_ff // Filtered overcurrent
);

	reg  [`BDC_OCF_CNT_W-1:0] cnt_ff;
	reg  [`BDC_OCF_CNT_W-1:0] limit;

	always @* begin
		case (filt_sel)
			2'h0:    limit = T0_CYC;
			2'h1:    limit = T1_CYC;
			2'h2:    limit = T2_CYC;
			default: limit = T3_CYC;
		endcase
	end

	// ****************************************************************
	// Flag after the input has stood high for limit cycles
	// ****************************************************************
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff     <= {`BDC_OCF_CNT_W{1'b0}};
			oc_flag_ff <= 1'b0;
		end else if (!oc_sync || amp_dis) begin
			cnt_ff     <= {`BDC_OCF_CNT_W{1'b0}};
			oc_flag_ff <= 1'b0;
		end else if (cnt_ff < limit - 1'b1) begin
			cnt_ff     <= cnt_ff + 1'b1;
		end else begin
			oc_flag_ff <= 1'b1;
		end
	end

endmodule // bdc_oc_filter

// File: verification/bdc_chk.sv
// Purpose : Concurrent checks on the register and flag ports of bdc_top.
// Assumes : One mclk domain, rst_n asynchronous and active low.
// Notes   : Bound to bdc_top after the module.
module bdc_chk (
	input wire logic	mclk,				// Core clock
	input wire logic	rst_n,				// Reset, active low
	input wire logic [4:0]	reg_addr,			// Offset
	input wire logic	reg_bank,			// Bank selector
	input wire logic	reg_wr,				// Write strobe
	input wire logic	reg_rd,				// Read strobe
	input wire logic [15:0]	reg_wdata,			// Write data
	input wire logic [15:0]	reg_rdata_ff,			// Read data
	input wire logic	reg_ack_ff,			// Answer pulse
	input wire logic	reg_hit_ff,			// Owned access
	input wire logic	oc1_flag_ff,			// Flag one
	input wire logic	oc2_flag_ff,			// Flag two
	input wire logic	amp1_level_select,		// Level one
	input wire logic	amp2_level_select,		// Level two
	input wire logic [1:0]	overcurrent1_filter_time,	// Filter one
	input wire logic [1:0]	overcurrent2_filter_time,	// Filter two
	input wire logic	amp1_disable,			// Off one
	input wire logic	amp2_disable,			// Off two
	input wire logic [7:0]	bridge_offstate_pulldown,	// Pull-downs
	input wire logic [7:0]	bridge_static_current_choice,	// Choices
	input wire logic [3:0]	static_current_level_one,	// Level code one
	input wire logic [3:0]	static_current_level_two	// Level code two
);
	// ****************************************************************
	// Field images and access decode
	// ****************************************************************
	wire [15:0] diag_v = {amp2_level_select, amp1_level_select, overcurrent2_filter_time,
		overcurrent1_filter_time, amp2_disable, amp1_disable, bridge_offstate_pulldown};
	wire [15:0] stat_v = {bridge_static_current_choice, static_current_level_two, static_current_level_one};
	wire acc = reg_wr | reg_rd;
	wire own = (reg_addr == 5'h09) || (reg_addr == 5'h0A && !reg_bank);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	ack_follows_a: assert property (acc |=> reg_ack_ff && reg_hit_ff == $past(own))
		else $error("access not answered as expected");
	idle_quiet_a: assert property (!acc |=> !reg_ack_ff && !reg_hit_ff)
		else $error("answer without access");
	bank_one_miss_a: assert property (acc && reg_addr == 5'h0A && reg_bank |=> !reg_hit_ff)
		else $error("bank one access claimed");
	diag_store_a: assert property (reg_wr && reg_addr == 5'h09 |=> diag_v == $past(reg_wdata))
		else $error("diag fields differ from write");
	stat_store_a: assert property (reg_wr && reg_addr == 5'h0A && !reg_bank |=> stat_v == $past(reg_wdata))
		else $error("static fields differ from write");
	cfg_hold_a: assert property (!(reg_wr && own) |=> $stable(diag_v) && $stable(stat_v))
		else $error("fields changed without write");
	diag_read_a: assert property (reg_rd && !reg_wr && reg_addr == 5'h09 |=> reg_rdata_ff == diag_v)
		else $error("diag read data wrong");
	miss_read_a: assert property (reg_rd && !own |=> reg_rdata_ff == 16'h0000)
		else $error("miss read data not zero");
	amp_off_quiet_a: assert property (amp1_disable && $past(amp1_disable) |-> !oc1_flag_ff)
		else $error("flag from disabled amplifier");
	amp2_off_quiet_a: assert property (amp2_disable && $past(amp2_disable) |-> !oc2_flag_ff)
		else $error("flag from disabled amplifier two");
	cover property (reg_wr && reg_addr == 5'h09);
	cover property (acc && reg_bank && reg_addr == 5'h0A);
	cover property ($rose(oc1_flag_ff));
endmodule // bdc_chk

bind bdc_top bdc_chk u_chk (.*);

// File: verification/bdc_host.sv
// Purpose : Host side model issuing one-cycle register strobes.
// Assumes : Requests start just after a rising mclk.
// Notes   : Address and data are scrambled while idle.
module bdc_host (
	input wire logic	mclk,		// Core clock
	output logic [4:0]	reg_addr,	// Offset
	output logic		reg_bank,	// Bank selector
	output logic		reg_wr,		// Write strobe
	output logic		reg_rd,		// Read strobe
	output logic [15:0]	reg_wdata,	// Write data
	input wire logic [15:0]	reg_rdata_ff,	// Read data
	input wire logic	reg_ack_ff,	// Answer pulse
	input wire logic	reg_hit_ff	// Owned access
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] rdat;
	logic [15:0] ahit;
	initial begin
		{reg_addr, reg_bank, reg_wr, reg_rd, reg_wdata} = '0;
	end
	task automatic xfer(input logic w, input logic [4:0] a, input logic b, input logic [15:0] d);
		@(posedge mclk);
		#5;
		reg_bank = b;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = w;
		reg_rd = !w;
		@(posedge mclk);
		#5;
		rdat = reg_rdata_ff;
		ahit = {14'h0000, reg_ack_ff, reg_hit_ff};
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
endmodule // bdc_host

// File: verification/tb_bridge_diag_current_config.sv
// Purpose : Self-checking bench for bdc_top register and flag behaviour.
// Assumes : 50 ns clock, strobes driven by bdc_host.
// Notes   : Filter counts run at full length.
module tb_bridge_diag_current_config;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, rst_n, oc1_raw, oc2_raw;
	wire [4:0] reg_addr;
	wire reg_bank, reg_wr, reg_rd, reg_ack_ff, reg_hit_ff, oc1_flag_ff, oc2_flag_ff;
	wire amp1_level_select, amp2_level_select, amp1_disable, amp2_disable;
	wire [15:0] reg_wdata, reg_rdata_ff;
	wire [1:0] overcurrent1_filter_time, overcurrent2_filter_time;
	wire [7:0] bridge_offstate_pulldown, bridge_static_current_choice;
	wire [3:0] static_current_level_one, static_current_level_two;
	wire [15:0] dg = {amp2_level_select, amp1_level_select, overcurrent2_filter_time,
		overcurrent1_filter_time, amp2_disable, amp1_disable, bridge_offstate_pulldown};
	wire [15:0] st = {bridge_static_current_choice, static_current_level_two, static_current_level_one};
	wire [15:0] fl = {14'h0000, oc2_flag_ff, oc1_flag_ff};
	logic [15:0] pat [4] = '{16'h0000, 16'hFFFF, 16'h5A81, 16'hA67E};
	logic [15:0] sp [3] = '{16'h8000, 16'h7C3B, 16'h03C5};
	int n_mismatch = 0;
	int cmp_count = 0;
	bdc_top u_dut (.*);
	bdc_host u_host (.*);
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic b, input logic [15:0] d, input logic h);
		u_host.xfer(1'b1, a, b, d);
		chk(u_host.ahit, {14'h0000, 1'b1, h});
	endtask
	task automatic rd(input logic [4:0] a, input logic b, input logic [15:0] e, input logic h);
		u_host.xfer(1'b0, a, b, 16'h0000);
		chk(u_host.ahit, {14'h0000, 1'b1, h});
		chk(u_host.rdat, e);
	endtask
	// Let n edges pass, then settle past the launching edge
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#5;
	endtask
	task automatic wrap_up;
		$display("Mismatches %0d of %0d comparisons", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#500000;
		n_mismatch++;
		wrap_up();
	end
	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial begin
		rst_n = 1'b0;
		oc1_raw = 1'b0;
		oc2_raw = 1'b0;
		repeat (5) @(posedge mclk);
		#5 rst_n = 1'b1;
		chk(dg, 16'hC000);
		rd(5'h09, 1'b0, 16'hC000, 1'b1);
		rd(5'h0A, 1'b0, 16'h0044, 1'b1);
		for (int i = 0; i < 4; i++) begin
			wr(5'h09, 1'b0, pat[i], 1'b1);
			chk(dg, pat[i]);
			rd(5'h09, 1'b0, pat[i], 1'b1);
		end
		for (int i = 0; i < 3; i++) begin
			wr(5'h0A, 1'b0, sp[i], 1'b1);
			chk(st, sp[i]);
		end
		wr(5'h0A, 1'b1, 16'hFFFF, 1'b0);
		rd(5'h0A, 1'b1, 16'h0000, 1'b0);
		rd(5'h0A, 1'b0, 16'h03C5, 1'b1);
		rd(5'h1F, 1'b0, 16'h0000, 1'b0);
		wr(5'h09, 1'b0, 16'h3000, 1'b1);
		oc1_raw = 1'b1;
		oc2_raw = 1'b1;
		tick(110);
		chk(fl, 16'h0000);
		tick(20);
		chk(fl, 16'h0001);
		tick(1860);
		chk(fl, 16'h0001);
		tick(20);
		chk(fl, 16'h0003);
		// Drop both inputs, then run the two middle filter codes
		oc1_raw = 1'b0;
		oc2_raw = 1'b0;
		tick(4);
		chk(fl, 16'h0000);
		wr(5'h09, 1'b0, 16'h2400, 1'b1);
		oc1_raw = 1'b1;
		oc2_raw = 1'b1;
		tick(190);
		chk(fl, 16'h0000);
		tick(20);
		chk(fl, 16'h0001);
		tick(780);
		chk(fl, 16'h0001);
		tick(20);
		chk(fl, 16'h0003);
		wr(5'h09, 1'b0, 16'h0300, 1'b1);
		tick(1);
		chk(fl, 16'h0000);
		oc1_raw = 1'b0;
		oc2_raw = 1'b0;
		rst_n = 1'b0;
		@(posedge mclk);
		#5 rst_n = 1'b1;
		rd(5'h0A, 1'b0, 16'h0044, 1'b1);
		rd(5'h09, 1'b0, 16'hC000, 1'b1);
		wrap_up();
	end
endmodule // tb_bridge_diag_current_config
